/* logic/flash_cmd_host.sv */
// host sequencer that issues flash command sequences in byte mode
`timescale 1ns/1ps
//==========================================================================
// Summary of operation
// - program suspend is one write of 51, resume one write of 50.
// - buffer load opens with 25 at sector, commit is 29 at sector.
// - one F0 write returns device to read mode.
// - fourth identification cycle is a write of 00 at address 0; upper data byte ignored.
// - identification code is read in three separate read cycles.
// - 98 at AA enters query, F0 or FF leaves it.
// - buffered write length follows count, at most 261 cycles.
// - after aborted buffer write issue AAA/AA, 555/55, AAA/F0.
// - buffer load count given is locations minus one.
// - every buffer location lies in the first address's page.
module flash_cmd_host
  import flash_cmd_pkg::*;
#(
  parameter int BUF_DEPTH = 256
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [3:0] req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic [8:0] req_count,
  output logic req_ready,
  output logic wdata_req,
  input wire logic [ADDR_W-1:0] wdata_addr,
  input wire logic [7:0] wdata_byte,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_ISSUE = 4'b0010, S_WAIT = 4'b0100, S_NEXT = 4'b1000
  } state_t;
  state_t state, next_state;
  op_t op, next_op;
  logic [8:0] step, next_step;
  logic [8:0] count, next_count;
  logic [ADDR_W-1:0] base, next_base;
  logic [7:0] data, next_data;
  logic [7:0] resp, next_resp;
  logic rvalid, next_rvalid;
  logic cyc_start, cyc_write, cyc_done, last;
  logic [ADDR_W-1:0] cyc_addr;
  logic [7:0] cyc_data, cyc_rdata;

  // low twelve address bits carry the code, upper bits zero (don't-care to device)
  function automatic logic [ADDR_W-1:0] low_addr(input logic [11:0] a);
    return {{(ADDR_W-12){1'b0}}, a};
  endfunction

  // sequence table: address, data, direction and last flag for each step
  always_comb begin
    cyc_addr = low_addr(ADDR_AAA);
    cyc_data = CMD_RESET;
    cyc_write = 1'b1;
    last = 1'b1;
    case (op)
      OP_READ: begin
        cyc_addr = base;
        cyc_write = 1'b0; // one read cycle per request, so an identity takes three
      end
      OP_STATUS: begin
        cyc_addr = base; // lane chosen by caller's bit 1
        cyc_write = 1'b0;
      end
      OP_PGM_SUSPEND: cyc_data = CMD_PGM_SUSPEND;
      OP_PGM_RESUME: cyc_data = CMD_PGM_RESUME;
      OP_ERASE_RESUME: cyc_data = CMD_ERASE_RESUME; // device ignores unless suspended
      OP_EVAL_ERASE: begin
        cyc_addr = {base[ADDR_W-1:12], ADDR_AAA};
        cyc_data = CMD_EVAL_ERASE;
      end
      OP_RESET: cyc_data = CMD_RESET;
      OP_QUERY: begin
        cyc_addr = low_addr(ADDR_QUERY);
        cyc_data = CMD_QUERY;
      end
      OP_QUERY_EXIT: cyc_data = CMD_EXIT_ALT;
      OP_SECURE_ENTRY, OP_ECC_ENTRY, OP_BUF_ABORT, OP_PROGRAM, OP_SECURE_EXIT: begin
        last = 1'b0;
        case (step)
          9'd0: cyc_data = CMD_UNLOCK1;
          9'd1: begin
            cyc_addr = low_addr(ADDR_555);
            cyc_data = CMD_UNLOCK2;
          end
          9'd2: begin
            last = (op != OP_PROGRAM && op != OP_SECURE_EXIT);
            cyc_data = (op == OP_SECURE_ENTRY) ? CMD_SECURE_ENTRY :
                       (op == OP_ECC_ENTRY) ? CMD_ECC_ENTRY :
                       (op == OP_BUF_ABORT) ? CMD_RESET :
                       (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_SECURE_EXIT;
          end
          default: begin
            last = 1'b1;
            cyc_addr = (op == OP_PROGRAM) ? base : '0; // caller picks sector
            cyc_data = (op == OP_PROGRAM) ? data : CMD_ZERO;
          end
        endcase
      end
      OP_BUF_WRITE: begin
        last = 1'b0;
        cyc_addr = base;
        if (step == 9'd0) begin
          cyc_data = CMD_UNLOCK1;
          cyc_addr = low_addr(ADDR_AAA);
        end else if (step == 9'd1) begin
          cyc_data = CMD_UNLOCK2;
          cyc_addr = low_addr(ADDR_555);
        end else if (step == 9'd2) begin
          cyc_data = CMD_BUF_LOAD;
        end else if (step == 9'd3) begin
          cyc_data = count[7:0]; // caller gives locations minus one
        end else if (step <= count + 9'd4) begin
          cyc_addr = wdata_addr; // caller keeps within page
          cyc_data = wdata_byte;
        end else begin
          cyc_data = CMD_BUF_COMMIT;
          last = 1'b1;
        end
      end
      OP_CONT_CHECK: begin
        last = (step == 9'd6);
        case (step)
          9'd0: cyc_data = CMD_CONT_START;
          9'd1, 9'd5: cyc_data = CMD_CONT_MARK;
          9'd3: begin
            cyc_addr = ADDR_CONT4;
            cyc_data = CMD_EXIT_ALT;
          end
          9'd4: begin
            cyc_addr = ADDR_CONT5;
            cyc_data = CMD_ZERO;
          end
          default: cyc_write = 1'b0; // steps 2 and 6 read
        endcase
      end
      default: cyc_data = CMD_RESET;
    endcase
  end

  assign wdata_req = (state == S_ISSUE) && op == OP_BUF_WRITE && step >= 9'd4
                     && step <= count + 9'd4;

  // sequencer next-state
  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_count = count;
    next_base = base;
    next_data = data;
    next_resp = resp;
    next_rvalid = 1'b0;
    cyc_start = 1'b0;
    case (state)
      S_IDLE: begin
        if (req_valid) begin
          next_op = op_t'(req_op);
          next_base = req_addr;
          next_data = req_data;
          // cap keeps sequence at 261 cycles: 5 overhead plus 256 loads
          next_count = (req_count > 9'(BUF_DEPTH - 1)) ? 9'(BUF_DEPTH - 1) : req_count;
          next_step = 9'd0;
          next_state = S_ISSUE;
        end
      end
      S_ISSUE: begin
        cyc_start = 1'b1;
        next_state = S_WAIT;
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (!cyc_write) begin
            next_resp = cyc_rdata; // only low byte exists
            next_rvalid = 1'b1;
          end
          next_state = last ? S_IDLE : S_NEXT;
        end
      end
      S_NEXT: begin
        next_step = step + 9'd1;
        next_state = S_ISSUE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      op <= OP_RESET;
      step <= 9'd0;
      count <= 9'd0;
      base <= '0;
      data <= 8'h00;
      resp <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      count <= next_count;
      base <= next_base;
      data <= next_data;
      resp <= next_resp;
      rvalid <= next_rvalid;
    end
  end

  assign req_ready = (state == S_IDLE);
  assign resp_valid = rvalid;
  assign resp_data = resp;

  flash_bus_cycle u_cycle (
    .clock(clock),
    .rst(rst),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in)
  );

  buf_length_a: assert property (@(posedge clock) disable iff (rst)
    op == OP_BUF_WRITE |-> step < 9'(BUF_MAX_CYCLES)) else $error("buffer sequence too long");
  suspend_code_a: assert property (@(posedge clock) disable iff (rst)
    cyc_start && op == OP_PGM_SUSPEND |-> cyc_write && cyc_data == 8'h51) else $error("bad suspend");
  commit_code_a: assert property (@(posedge clock) disable iff (rst)
    cyc_start && op == OP_BUF_WRITE && last |-> cyc_data == 8'h29 && cyc_addr == base)
    else $error("bad commit");
  abort_seq_a: assert property (@(posedge clock) disable iff (rst)
    cyc_start && op == OP_BUF_ABORT && step == 9'd2 |-> cyc_data == 8'hF0 && last)
    else $error("bad abort tail");
  query_code_a: assert property (@(posedge clock) disable iff (rst)
    cyc_start && op == OP_QUERY |-> cyc_addr == 23'h0000AA && cyc_data == 8'h98)
    else $error("bad query");
  cont_read_a: assert property (@(posedge clock) disable iff (rst)
    cyc_start && op == OP_CONT_CHECK && (step == 9'd2 || step == 9'd6) |-> !cyc_write)
    else $error("continuity read missing");
  read_direct_a: assert property (@(posedge clock) disable iff (rst)
    state == S_IDLE && req_valid && req_op == 4'h0 |-> ##1 state == S_ISSUE ##1 !cyc_write)
    else $error("read not direct");
  reset_code_a: assert property (@(posedge clock) disable iff (rst)
    cyc_start && op == OP_RESET |-> cyc_data == 8'hF0 && last) else $error("bad reset");
endmodule : flash_cmd_host

/* common/flash_cmd_pkg.sv */
// package: command codes, addresses and bus timing for the flash command sequencer
package flash_cmd_pkg;
  localparam int ADDR_W = 23;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PGM_SUSPEND = 8'h51;
  localparam logic [7:0] CMD_PGM_RESUME = 8'h50;
  localparam logic [7:0] CMD_EVAL_ERASE = 8'h35;
  localparam logic [7:0] CMD_SECURE_ENTRY = 8'h88;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_COMMIT = 8'h29;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_EXIT_ALT = 8'hFF;
  localparam logic [7:0] CMD_SECURE_EXIT = 8'h90;
  localparam logic [7:0] CMD_ZERO = 8'h00;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_CONT_START = 8'h71;
  localparam logic [7:0] CMD_CONT_MARK = 8'h70;
  localparam logic [7:0] CMD_ECC_ENTRY = 8'h75;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'h30;
  localparam logic [11:0] ADDR_AAA = 12'hAAA;
  localparam logic [11:0] ADDR_555 = 12'h555;
  localparam logic [11:0] ADDR_QUERY = 12'h0AA;
  localparam logic [ADDR_W-1:0] ADDR_CONT4 = 23'h5554AB;
  localparam logic [ADDR_W-1:0] ADDR_CONT5 = 23'h2AAB54;
  localparam int BUF_MAX_CYCLES = 261;
  localparam int CLK_NS = 50;
  localparam int T_STROBE_NS = 70;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  // operation codes on the host command port
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_PGM_SUSPEND = 4'h1, OP_PGM_RESUME = 4'h2, OP_EVAL_ERASE = 4'h3,
    OP_SECURE_ENTRY = 4'h4, OP_PROGRAM = 4'h5, OP_BUF_WRITE = 4'h6, OP_BUF_ABORT = 4'h7,
    OP_SECURE_EXIT = 4'h8, OP_RESET = 4'h9, OP_QUERY = 4'hA, OP_QUERY_EXIT = 4'hB,
    OP_CONT_CHECK = 4'hC, OP_ECC_ENTRY = 4'hD, OP_ERASE_RESUME = 4'hE, OP_STATUS = 4'hF
  } op_t;
endpackage : flash_cmd_pkg

/* logic/flash_bus_cycle.sv */
// single read or write cycle on the flash pins, strobes framed by a cycle counter
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_cmd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in
);
  typedef enum logic [2:0] {
    B_IDLE = 3'b001, B_STROBE = 3'b010, B_DONE = 3'b100
  } bstate_t;
  bstate_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic wr, next_wr;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [7:0] next_dq_out, next_rdata;
  logic [7:0] sync1, sync2, sync3;

  // read data passes three flops; accept when second and third agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= flash_dq_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // next-state for the cycle sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_flash_addr = flash_addr;
    next_dq_out = flash_dq_out;
    next_rdata = rdata;
    case (state)
      B_IDLE: begin
        if (start) begin
          next_state = B_STROBE;
          next_cnt = 4'(STROBE_CYC + 3);
          next_wr = is_write;
          next_flash_addr = addr;
          next_dq_out = wdata;
        end
      end
      B_STROBE: begin
        if (cnt == 4'h0) begin
          next_state = B_DONE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
        if (!wr && sync2 == sync3) begin
          next_rdata = sync3;
        end
      end
      B_DONE: next_state = B_IDLE;
      default: next_state = B_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= B_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      flash_addr <= next_flash_addr;
      flash_dq_out <= next_dq_out;
      rdata <= next_rdata;
    end
  end

  // strobes: write ends one cycle before the frame so data holds past the rising edge
  assign flash_ce_n = (state != B_STROBE);
  assign flash_we_n = !(state == B_STROBE && wr && cnt != 4'h0);
  assign flash_oe_n = !(state == B_STROBE && !wr);
  assign flash_dq_oe_n = !(state == B_STROBE && wr);
  assign done = (state == B_DONE);

  strobe_excl_a: assert property (@(posedge clock) disable iff (rst)
    !(!flash_we_n && !flash_oe_n)) else $error("write and output enable both active");
  dq_drive_a: assert property (@(posedge clock) disable iff (rst)
    !flash_we_n |-> !flash_dq_oe_n) else $error("write strobe without data drive");
endmodule : flash_bus_cycle

/* dv/flash_dev_model.sv */
// behavioural byte-mode flash: logs bus cycles and answers reads by mode
`timescale 1ns/1ps
module flash_dev_model
  import flash_cmd_pkg::*;
(
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  output logic [7:0] flash_dq_in
);
  // log entry: read flag, low address bits, data; full address kept beside it
  logic [20:0] lg [$];
  logic [ADDR_W-1:0] la [$];
  int mode = 0; // 0 array, 1 query, 2 correction, 3 secure, 4 status, 5 identification
  int unl = 0;
  int ld = 0; // buffer writes still to come, -1 while the count byte is awaited
  logic [7:0] last = 8'h00;
  logic [7:0] rval;
  logic [7:0] wd;
  //==========================================================================
  // read data by mode
  always_comb begin
    case (mode)
      1: rval = {4'hA, flash_addr[3:0]};
      2: rval = {7'h00, flash_addr[0]};
      4: rval = flash_addr[1] ? 8'h12 : 8'h80;
      // identification pattern is arbitrary; protect verify at offset 04 reads unprotected
      5: rval = (flash_addr[7:0] == 8'h04) ? 8'h00 : {3'b101, flash_addr[4:0]};
      default: rval = flash_addr[7:0] ^ 8'h3C;
    endcase
  end
  // released bus shows the inverse of the last value, never a stale copy
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rval : ~last;
  // command decode; unlock matching looks at the low twelve address bits only
  task automatic decode(input logic [11:0] a, input logic [7:0] d);
    if (ld < 0) ld = int'(d) + 2; // count byte: loads and the commit follow
    else if (ld > 0) ld--; // buffer data is never decoded as a command
    else if (d == 8'hF0) mode = 0;
    else if (d == 8'hFF && mode == 1) mode = 0;
    else if (d == 8'h98 && a == 12'h0AA && (mode == 0 || mode == 5)) mode = 1;
    else if (d == 8'h70 && a == 12'hAAA) mode = 4;
    else if (unl == 2 && a == 12'hAAA && d == 8'h75) mode = 2;
    else if (unl == 2 && a == 12'hAAA && d == 8'h88) mode = 3;
    else if (unl == 2 && a == 12'hAAA && d == 8'h90) mode = (mode == 3) ? 0 : 5;
    else if (unl == 2 && d == 8'h25) ld = -1;
    unl = (a == 12'hAAA && d == 8'hAA) ? 1 :
      (unl == 1 && a == 12'h555 && d == 8'h55) ? 2 : 0;
  endtask : decode
  // one bus cycle per chip select; write data latched at the strobe's rise
  always @(negedge flash_ce_n) begin
    #1;
    if (!flash_oe_n) begin
      lg.push_back(21'h100000);
      la.push_back(flash_addr);
      @(posedge flash_oe_n or posedge flash_ce_n);
      last = rval;
    end else if (!flash_we_n) begin
      @(posedge flash_we_n or posedge flash_ce_n);
      wd = flash_dq_oe_n ? 8'hEE : flash_dq_out;
      lg.push_back({1'b0, flash_addr[11:0], wd});
      la.push_back(flash_addr);
      decode(flash_addr[11:0], wd);
    end
  end
endmodule : flash_dev_model

/* dv/flash_cmd_host_tb.sv */
// self-checking bench: host sequencer driving a behavioural byte-mode flash
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module flash_cmd_host_tb;
  import flash_cmd_pkg::*;
  localparam logic [11:0] ANY = 12'hFFF; // address left uncompared
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, wdata_prev = 1'b0;
  logic [3:0] req_op = 4'h0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [7:0] req_data = 8'h00, got = 8'h00;
  logic [8:0] req_count = 9'h000;
  logic req_ready, wdata_req, resp_valid, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n;
  logic [ADDR_W-1:0] flash_addr, wdata_addr;
  logic [7:0] resp_data, flash_dq_out, flash_dq_in, wdata_byte;
  int fail_count = 0, n_compared = 0, ld_idx = 0, ld0 = 0, base = 0;
  logic [20:0] e [$];
  //==========================================================================
  // clock, load index and read capture
  always #25 clock = ~clock;
  always @(posedge clock) begin
    wdata_prev <= wdata_req;
    if (wdata_prev && !wdata_req) ld_idx <= ld_idx + 1;
    if (resp_valid === 1'b1) got <= resp_data;
  end
  // buffer locations follow the first program address within its page
  assign wdata_addr = req_addr + ADDR_W'(ld_idx - ld0);
  assign wdata_byte = 8'hC0 + 8'(ld_idx - ld0);
  flash_cmd_host u_flash_cmd_host (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_count(req_count),
    .req_ready(req_ready), .wdata_req(wdata_req), .wdata_addr(wdata_addr),
    .wdata_byte(wdata_byte), .resp_valid(resp_valid), .resp_data(resp_data),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in));
  flash_dev_model u_flash_dev_model (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in));
  //==========================================================================
  // helpers
  function automatic logic [20:0] w(input logic [11:0] a, input logic [7:0] d);
    return {1'b0, a, d};
  endfunction : w
  task automatic pu(input logic [7:0] d);
    e = '{w(12'hAAA, 8'hAA), w(12'h555, 8'h55), w(12'hAAA, d)};
  endtask : pu
  // one request, held for one clock, then wait for the sequence to end
  task automatic run(input logic [3:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      input logic [8:0] c);
    int n;
    base = u_flash_dev_model.lg.size();
    @(posedge clock);
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_count <= c;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    `CHK("ready", 1'b1, req_ready)
    repeat (3) @(negedge clock);
  endtask : run
  // compare logged bus cycles of the last request with the expected list
  task automatic seq(input string nm);
    logic [20:0] g;
    `CHK(nm, e.size(), u_flash_dev_model.lg.size() - base)
    foreach (e[i]) begin
      g = u_flash_dev_model.lg[base + i];
      if (e[i][19:8] == ANY) g[19:8] = ANY;
      `CHK(nm, e[i], g)
    end
    e.delete();
  endtask : seq
  //==========================================================================
  // scenarios
  task automatic t_read();
    run(OP_READ, 23'h012345, 8'h00, 9'h000);
    e = '{21'h100000};
    seq("array read");
    `CHK("array data", 8'h79, got)
    `CHK("read address", 23'h012345, u_flash_dev_model.la[base])
    $display("test array read done");
  endtask : t_read
  task automatic t_suspend();
    run(OP_PGM_SUSPEND, 23'h000000, 8'h00, 9'h000);
    e = '{w(ANY, 8'h51)};
    seq("suspend");
    run(OP_PGM_RESUME, 23'h000000, 8'h00, 9'h000);
    e = '{w(ANY, 8'h50)};
    seq("resume");
    $display("test suspend resume done");
  endtask : t_suspend
  task automatic t_secure();
    run(OP_SECURE_ENTRY, 23'h000000, 8'h00, 9'h000);
    pu(8'h88);
    seq("secure entry");
    run(OP_PROGRAM, 23'h000123, 8'h5A, 9'h000);
    pu(8'hA0);
    e.push_back(w(12'h123, 8'h5A));
    seq("secure program");
    run(OP_SECURE_EXIT, 23'h000000, 8'h00, 9'h000);
    pu(8'h90);
    e.push_back(w(ANY, 8'h00));
    seq("secure exit");
    $display("test secure region done");
  endtask : t_secure
  // unlock then 90 outside the secure region opens identification reads
  task automatic t_ident();
    run(OP_SECURE_EXIT, 23'h000000, 8'h00, 9'h000);
    run(OP_READ, 23'h000002, 8'h00, 9'h000);
    `CHK("ident 1", 8'hA2, got)
    run(OP_READ, 23'h00001C, 8'h00, 9'h000);
    `CHK("ident 2", 8'hBC, got)
    run(OP_READ, 23'h00001E, 8'h00, 9'h000);
    `CHK("ident 3", 8'hBE, got)
    run(OP_READ, 23'h040004, 8'h00, 9'h000);
    `CHK("protect verify", 8'h00, got)
    run(OP_RESET, 23'h000000, 8'h00, 9'h000);
    run(OP_READ, 23'h000002, 8'h00, 9'h000);
    `CHK("ident exit", 8'h3E, got)
    $display("test identification done");
  endtask : t_ident
  task automatic t_buffer(input logic [ADDR_W-1:0] sa, input logic [8:0] c);
    ld0 = ld_idx;
    run(OP_BUF_WRITE, sa, 8'h00, c);
    e = '{w(12'hAAA, 8'hAA), w(12'h555, 8'h55), w(sa[11:0], 8'h25), w(sa[11:0], c[7:0])};
    for (int k = 0; k <= c; k++) e.push_back(w(sa[11:0] + 12'(k), 8'hC0 + 8'(k)));
    e.push_back(w(sa[11:0], 8'h29));
    `CHK("cycle limit", 1'b1, u_flash_dev_model.lg.size() - base <= 261)
    seq("buffer write");
    $display("test buffer write done");
  endtask : t_buffer
  task automatic t_query();
    run(OP_QUERY, 23'h000000, 8'h00, 9'h000);
    e = '{w(12'h0AA, 8'h98)};
    seq("query entry");
    run(OP_READ, 23'h000013, 8'h00, 9'h000);
    `CHK("query data", 8'hA3, got)
    run(OP_QUERY_EXIT, 23'h000000, 8'h00, 9'h000);
    e = '{w(ANY, 8'hFF)};
    seq("query exit");
    run(OP_READ, 23'h000013, 8'h00, 9'h000);
    `CHK("array after exit", 8'h2F, got)
    run(OP_QUERY, 23'h000000, 8'h00, 9'h000);
    run(OP_RESET, 23'h000000, 8'h00, 9'h000);
    e = '{w(ANY, 8'hF0)};
    seq("reset");
    run(OP_READ, 23'h000014, 8'h00, 9'h000);
    `CHK("array after reset", 8'h28, got)
    $display("test query done");
  endtask : t_query
  task automatic t_ecc();
    run(OP_ECC_ENTRY, 23'h000000, 8'h00, 9'h000);
    pu(8'h75);
    seq("ecc entry");
    run(OP_READ, 23'h000021, 8'h00, 9'h000);
    `CHK("ecc status", 8'h01, got)
    run(OP_RESET, 23'h000000, 8'h00, 9'h000);
    run(OP_READ, 23'h000021, 8'h00, 9'h000);
    `CHK("ecc exit", 8'h1D, got)
    $display("test ecc overlay done");
  endtask : t_ecc
  task automatic t_misc();
    run(OP_EVAL_ERASE, 23'h050AAA, 8'h00, 9'h000);
    e = '{w(12'hAAA, 8'h35)};
    seq("evaluate erase");
    run(OP_ERASE_RESUME, 23'h000000, 8'h00, 9'h000);
    e = '{w(ANY, 8'h30)};
    seq("erase resume");
    run(OP_PROGRAM, 23'h060010, 8'h3C, 9'h000);
    pu(8'hA0);
    e.push_back(w(12'h010, 8'h3C));
    seq("program other sector");
    run(OP_BUF_ABORT, 23'h000000, 8'h00, 9'h000);
    pu(8'hF0);
    seq("abort reset");
    $display("test single writes done");
  endtask : t_misc
  task automatic t_cont();
    run(OP_CONT_CHECK, 23'h000000, 8'h00, 9'h000);
    e = '{w(12'hAAA, 8'h71), w(12'hAAA, 8'h70), 21'h100000, w(12'h4AB, 8'hFF),
      w(12'hB54, 8'h00), w(12'hAAA, 8'h70), 21'h100000};
    seq("continuity");
    `CHK("cont addr4", 23'h5554AB, u_flash_dev_model.la[base + 3])
    `CHK("cont addr5", 23'h2AAB54, u_flash_dev_model.la[base + 4])
    $display("test continuity done");
  endtask : t_cont
  task automatic t_status();
    run(OP_STATUS, 23'h000002, 8'h00, 9'h000);
    `CHK("upper lane", 8'h12, got)
    run(OP_STATUS, 23'h000000, 8'h00, 9'h000);
    `CHK("lower lane", 8'h80, got)
    $display("test status lanes done");
  endtask : t_status
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  //==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_read();
    t_suspend();
    t_secure();
    t_ident();
    t_buffer(23'h040200, 9'd2);
    t_buffer(23'h041100, 9'd255);
    t_query();
    t_ecc();
    t_misc();
    t_cont();
    t_status();
    results();
  end
  initial begin
    #(50 * 30000);
    fail_count++;
    results();
  end
endmodule : flash_cmd_host_tb
